// ===== inc/mib_pkg.sv
// statistics counter readout: register offsets, selection codes, field positions
// assumes byte-wide register access and one system clock
package mib_pkg;

   // ------------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_SELECT = 8'h6E;
   localparam logic [7:0] OFS_INDEX = 8'h6F;
   localparam logic [7:0] OFS_RESULT_4 = 8'h74;
   localparam logic [7:0] OFS_RESULT_3 = 8'h75;
   localparam logic [7:0] OFS_RESULT_2 = 8'h76;
   localparam logic [7:0] OFS_RESULT_1 = 8'h77;
   localparam logic [7:0] OFS_RESULT_0 = 8'h78;

   // ------------------------------------------------------------------
   // selection codes, reset values, widths
   // ------------------------------------------------------------------
   localparam logic [7:0] SEL_PORT_SPACE = 8'h1C;
   localparam logic [7:0] SEL_ALL_SPACE = 8'h1D;
   localparam logic [7:0] SELECT_RESET = 8'h00;
   localparam logic [7:0] INDEX_RESET = 8'h00;
   localparam logic [7:0] RDATA_RESET = 8'h00;
   localparam int ADDR_W = 9;
   localparam int COUNT_W = 36;
   localparam int AMOUNT_W = 16;
   localparam int RESULT_W = 40;

   // ------------------------------------------------------------------
   // result field positions
   // ------------------------------------------------------------------
   localparam int OVF_BIT = 38;
   localparam int VALID_BIT = 37;
   localparam int TOTAL_RSVD_BIT = 36;
   localparam int DROP_RSVD_LSB = 16;

   // ------------------------------------------------------------------
   // counter space layout
   // ------------------------------------------------------------------
   localparam logic [2:0] RESERVED_BLOCK = 3'h3;
   localparam logic [2:0] LAST_PORT_BLOCK = 3'h4;
   localparam logic [3:0] ALL_PORT_HIGH = 4'h0;
   localparam logic [35:0] PER_PORT_MASK = 36'h03FFFFFFF;
   localparam logic [35:0] TOTAL_BYTES_MASK = 36'hFFFFFFFFF;
   localparam logic [35:0] DROP_MASK = 36'h00000FFFF;
   localparam logic [36:0] ENTRY_RESET = 37'h0000000000;

   // valid entry: five 32-entry port blocks less the reserved one, then 16 all-port
   function automatic logic entry_ok(input logic [8:0] a);
      entry_ok = a[8] ? (a[7:4] == ALL_PORT_HIGH)
                      : ((a[7:5] != RESERVED_BLOCK) && (a[7:5] <= LAST_PORT_BLOCK));
   endfunction : entry_ok

   // all-port entries: bit 1 clear for byte counts, set for drop counts
   function automatic logic is_drop(input logic [8:0] a);
      is_drop = a[8] & a[1];
   endfunction : is_drop

   function automatic logic [35:0] entry_mask(input logic [8:0] a);
      if (!entry_ok(a))
         entry_mask = 36'h000000000;
      else if (!a[8])
         entry_mask = PER_PORT_MASK;
      else if (is_drop(a))
         entry_mask = DROP_MASK;
      else
         entry_mask = TOTAL_BYTES_MASK;
   endfunction : entry_mask

endpackage : mib_pkg

// ===== inc/mib_store_if.sv
// carrier between the readout control and the counter store
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface mib_store_if;
   logic req;
   logic [8:0] req_addr;
   logic add_valid;
   logic [8:0] add_index;
   logic [15:0] add_amount;
   logic rsp_valid;
   logic [35:0] rsp_count;
   logic rsp_ovf;

   modport ctrl (output req, output req_addr, output add_valid, output add_index,
                 output add_amount, input rsp_valid, input rsp_count, input rsp_ovf);
   modport store (input req, input req_addr, input add_valid, input add_index,
                  input add_amount, output rsp_valid, output rsp_count, output rsp_ovf);
endinterface : mib_store_if
`default_nettype wire

// ===== hdl/mib_counter_store.sv
// counter array with add port and read-and-clear port
// assumes add events come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module mib_counter_store
(
   input wire logic clk,
   input wire logic rst,
   mib_store_if.store sif
);
   localparam int DEPTH = 1 << mib_pkg::ADDR_W;

   // ------------------------------------------------------------------
   // storage: overflow flag above the count
   // ------------------------------------------------------------------
   logic [36:0] mem [DEPTH];

   wire logic add_hit;
   wire logic [35:0] add_mask;
   wire logic [36:0] add_sum;
   wire logic [36:0] add_next;
   wire logic same_entry;
   wire logic [36:0] clear_next;
   wire logic [36:0] read_entry;

   // wrap at the entry's width and remember that it wrapped
   assign add_hit = sif.add_valid & mib_pkg::entry_ok(sif.add_index);
   assign add_mask = mib_pkg::entry_mask(sif.add_index);
   assign add_sum = {1'b0, mem[sif.add_index][35:0]} + {21'h000000, sif.add_amount};
   assign add_next = {mem[sif.add_index][36] | (|(add_sum & ~{1'b0, add_mask})),
                      add_sum[35:0] & add_mask};
   // an add landing on the entry being cleared survives the clear
   assign same_entry = add_hit & (sif.add_index == sif.req_addr);
   assign clear_next = same_entry ? {21'h000000, sif.add_amount} : mib_pkg::ENTRY_RESET;
   assign read_entry = mem[sif.req_addr];

   // array update; the clear is written last so it overrides the plain add
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem[i] <= mib_pkg::ENTRY_RESET;
      end
      else
      begin
         if (add_hit)
            mem[sif.add_index] <= add_next;
         if (sif.req)
            mem[sif.req_addr] <= clear_next;
      end
   end

   // answer one cycle after the request, value taken before the clear
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sif.rsp_valid <= 1'b0;
         sif.rsp_count <= 36'h000000000;
         sif.rsp_ovf <= 1'b0;
      end
      else
      begin
         sif.rsp_valid <= sif.req;
         sif.rsp_count <= read_entry[35:0];
         sif.rsp_ovf <= read_entry[36];
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   read_clears_a: assert property (@(posedge clk) disable iff (rst)
      sif.req && !same_entry |=> mem[$past(sif.req_addr)] == mib_pkg::ENTRY_RESET)
      else $error("counter not cleared after readout");
   latch_before_clear_a: assert property (@(posedge clk) disable iff (rst)
      sif.req |=> sif.rsp_valid && sif.rsp_count == $past(read_entry[35:0]))
      else $error("readout value not the value before clear");

endmodule : mib_counter_store
`default_nettype wire

// ===== hdl/mib_counter_indirect_readout.sv
// statistics counters and their indirect readout through byte registers
// assumes the register port and event inputs are on clk; one byte access per cycle
//
// Contract
// - total-byte counters return count in bits 35..0, bit 36 zero.
// - drop counters return count in bits 15..0, bits 36..16 zero.
// - result bit 38 shows that the counter overflowed; zero after reset.
// - result bit 37 shows the value is valid; zero while pending.
// - every counter clears when read out; all counters reset to zero.
// - thirty-six counters per port, each readable indirectly.
// - select code 0x1C in register 110 picks the per-port counter space.
// - select code 0x1D in register 110 picks the all-port counters.
// - writing the index byte to register 111 starts the read.
// - with all-port space, index 0x03 fetches port 1 transmit drops.
// - result appears in registers 116..120, most significant byte first.
// - per-port blocks of 32: bases 0, 0x20, 0x40, reserved 0x60, 0x80.
// - all-port counters from 0x100, four per port, rx/tx bytes then drops.
`timescale 1ns/1ps
`default_nettype none
module mib_counter_indirect_readout
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic event_valid,
   input wire logic [8:0] event_index,
   input wire logic [15:0] event_amount
);

   // ------------------------------------------------------------------
   // registers and state
   // ------------------------------------------------------------------
   logic [7:0] select;
   logic [7:0] index;
   logic [8:0] result_addr;
   logic [35:0] result_count;
   logic result_ovf;
   logic result_valid;
   logic req;
   logic [8:0] req_addr;

   mib_store_if sif ();

   // ------------------------------------------------------------------
   // access decode
   // ------------------------------------------------------------------
   wire logic wr_select;
   wire logic wr_index;
   wire logic space_ok;
   wire logic trig;
   wire logic [8:0] trig_addr;
   wire logic [39:0] result;
   wire logic [7:0] read_mux;
   wire logic next_valid;

   assign wr_select = reg_wr & (reg_addr == mib_pkg::OFS_SELECT);
   assign wr_index = reg_wr & (reg_addr == mib_pkg::OFS_INDEX);
   // only the two counter-space codes arm the trigger; other codes leave it inert
   assign space_ok = (select == mib_pkg::SEL_PORT_SPACE)
                   | (select == mib_pkg::SEL_ALL_SPACE);
   assign trig = wr_index & space_ok;
   assign trig_addr = {select[0], reg_wdata};

   // result word: bit 39 and bit 36 are always zero
   assign result = {1'b0, result_ovf, result_valid, 1'b0, result_count};

   // byte selection, most significant at the lowest offset
   assign read_mux = (reg_addr == mib_pkg::OFS_SELECT) ? select :
                     (reg_addr == mib_pkg::OFS_INDEX) ? index :
                     (reg_addr == mib_pkg::OFS_RESULT_4) ? result[39:32] :
                     (reg_addr == mib_pkg::OFS_RESULT_3) ? result[31:24] :
                     (reg_addr == mib_pkg::OFS_RESULT_2) ? result[23:16] :
                     (reg_addr == mib_pkg::OFS_RESULT_1) ? result[15:8] :
                     (reg_addr == mib_pkg::OFS_RESULT_0) ? result[7:0] :
                     mib_pkg::RDATA_RESET;

   // a new trigger withdraws validity; an answer only counts when nothing newer is in flight
   assign next_valid = trig ? 1'b0 :
                       (sif.rsp_valid & ~req) ? 1'b1 : result_valid;

   // ------------------------------------------------------------------
   // store connection
   // ------------------------------------------------------------------
   assign sif.req = req;
   assign sif.req_addr = req_addr;
   assign sif.add_valid = event_valid;
   assign sif.add_index = event_index;
   assign sif.add_amount = event_amount;

   mib_counter_store u_store
   (
      .clk(clk),
      .rst(rst),
      .sif(sif)
   );

   // ------------------------------------------------------------------
   // host-written registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         select <= mib_pkg::SELECT_RESET;
         index <= mib_pkg::INDEX_RESET;
      end
      else
      begin
         if (wr_select)
            select <= reg_wdata;
         if (wr_index)
            index <= reg_wdata;
      end
   end

   // trigger to store request, one cycle later
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         req <= 1'b0;
         req_addr <= 9'h000;
      end
      else
      begin
         req <= trig;
         req_addr <= trig ? trig_addr : req_addr;
      end
   end

   // result latch; the store already masks each entry to its own width
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         result_count <= 36'h000000000;
         result_ovf <= 1'b0;
         result_valid <= 1'b0;
         result_addr <= 9'h000;
      end
      else
      begin
         result_valid <= next_valid;
         if (trig)
            result_addr <= trig_addr;
         if (sif.rsp_valid)
         begin
            result_count <= sif.rsp_count;
            result_ovf <= sif.rsp_ovf;
         end
      end
   end

   // read data holds until the next read strobe
   always_ff @(posedge clk)
   begin
      if (rst)
         reg_rdata <= mib_pkg::RDATA_RESET;
      else if (reg_rd)
         reg_rdata <= read_mux;
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   sequence trig_s;
      trig;
   endsequence

   sequence quiet_two_s;
      !trig [*2];
   endsequence

   select_store_a: assert property (@(posedge clk) disable iff (rst)
      wr_select |=> select == $past(reg_wdata))
      else $error("select register not updated");

   trigger_req_a: assert property (@(posedge clk) disable iff (rst)
      trig_s |=> req && req_addr == {$past(select[0]), $past(reg_wdata)})
      else $error("trigger did not request the formed address");

   bad_space_a: assert property (@(posedge clk) disable iff (rst)
      wr_index && !space_ok |=> !req)
      else $error("read started with a foreign select code");

   valid_drop_a: assert property (@(posedge clk) disable iff (rst)
      trig_s |=> !result_valid ##1 !result_valid)
      else $error("result valid while read pending");

   valid_rise_a: assert property (@(posedge clk) disable iff (rst)
      trig_s ##1 quiet_two_s |=> result_valid)
      else $error("result not valid three cycles after trigger");

   high_byte_a: assert property (@(posedge clk) disable iff (rst)
      reg_rd && reg_addr == mib_pkg::OFS_RESULT_4 |=> reg_rdata == $past(result[39:32]))
      else $error("flag byte read wrong");

   total_reserved_a: assert property (@(posedge clk) disable iff (rst)
      result_valid && result_addr[8] && !mib_pkg::is_drop(result_addr)
      |-> result[mib_pkg::TOTAL_RSVD_BIT] == 1'b0)
      else $error("total byte result reserved bit set");

   drop_reserved_a: assert property (@(posedge clk) disable iff (rst)
      result_valid && mib_pkg::is_drop(result_addr)
      |-> result[mib_pkg::TOTAL_RSVD_BIT:mib_pkg::DROP_RSVD_LSB] == 21'h000000)
      else $error("drop counter result reserved bits set");

   ovf_flag_a: assert property (@(posedge clk) disable iff (rst)
      sif.rsp_valid |=> result[mib_pkg::OVF_BIT] == $past(sif.rsp_ovf))
      else $error("overflow flag not carried to result");

endmodule : mib_counter_indirect_readout
`default_nettype wire

// ===== sim/mib_host_model.sv
// host model: the processor that reaches the counters through the byte registers
// assumes strobes may change 1 ns after a rising edge and are held for one edge
`timescale 1ns/1ps
`default_nettype none
module mib_host_model
(
   input wire logic clk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   // idle bus from time zero
   initial
   begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end

   // one write; only the strobe is dropped so a read may start in the same step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
   endtask : wr

   // one read; now skips the leading edge, data is taken a full edge later for margin
   task automatic rd(input logic [7:0] a, input logic now, output logic [7:0] d);
      if (!now)
      begin
         @(posedge clk);
         #1;
      end
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      @(posedge clk);
      #1;
      d = reg_rdata;
   endtask : rd

   // result bytes, top first; a drop count needs only the flag and low bytes
   task automatic get(input logic drop, output logic [39:0] res);
      logic [7:0] b;
      res = 40'h0000000000;
      @(posedge clk);
      for (int k = 0; k < 5; k++)
      begin
         b = 8'h00;
         if (!(drop && (k == 1 || k == 2)))
            rd(mib_pkg::OFS_RESULT_4 + 8'(k), 1'b0, b);
         res = {res[31:0], b};
      end
   endtask : get

   // select the space, write the index to trigger, then collect the result
   // the bench drives one drop counter past its 16 bits to check the wrap and its flag
   task automatic fetch(input logic [7:0] sel, input logic [7:0] idx, output logic [39:0] res);
      wr(mib_pkg::OFS_SELECT, sel);
      wr(mib_pkg::OFS_INDEX, idx);
      get(sel[0] & idx[1], res);
   endtask : fetch
endmodule : mib_host_model
`default_nettype wire

// ===== sim/mib_counter_indirect_readout_tb.sv
// testbench: counter readout through the host model, events driven directly
// assumes the design answers per its hand-over walk at 10 MHz
`timescale 1ns/1ps
`default_nettype none
module mib_counter_indirect_readout_tb;
   typedef struct {logic [7:0] sel; logic [7:0] idx; logic [15:0] amt; int n;
                   logic [39:0] exp;} row_t;
   logic clk, rst, reg_wr, reg_rd, event_valid;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, b;
   logic [8:0] event_index;
   logic [15:0] event_amount;
   logic [39:0] res;
   int failures = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [7:0] probe [8] = '{8'h6E, 8'h6F, 8'h74, 8'h75, 8'h76, 8'h77, 8'h78, 8'h70};
   row_t rows [8] = '{
      '{8'h1C, 8'h0D, 16'h0005, 1, 40'h2000000005},
      '{8'h1C, 8'h2D, 16'h0007, 1, 40'h2000000007},
      '{8'h1C, 8'h9F, 16'h0001, 3, 40'h2000000003},
      '{8'h1D, 8'h03, 16'h0009, 1, 40'h2000000009},
      '{8'h1D, 8'h00, 16'hFFFF, 2, 40'h200001FFFE},
      '{8'h1D, 8'h02, 16'h8000, 2, 40'h6000000000},
      '{8'h1D, 8'h0F, 16'h0004, 1, 40'h2000000004},
      '{8'h1C, 8'h60, 16'h0005, 1, 40'h2000000000}};

   // ------------------------------------------------------------------
   // clock, design, host
   // ------------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   mib_counter_indirect_readout dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .event_valid(event_valid), .event_index(event_index), .event_amount(event_amount));

   mib_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string msg);
      n_tests++;
      if (got !== exp)
      begin
         $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
         failures++;
      end
   endtask : chk

   // one counting event held for exactly one edge
   task automatic ev(input logic [8:0] a, input logic [15:0] amt);
      @(posedge clk);
      #1;
      event_valid = 1'b1;
      event_index = a;
      event_amount = amt;
      @(posedge clk);
      #1;
      event_valid = 1'b0;
   endtask : ev

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   // a hang is cut short well beyond the few hundred cycles the run needs
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         failures++;
         final_report();
      end
   end

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial
   begin
      rst = 1'b1;
      event_valid = 1'b0;
      event_index = 9'h000;
      event_amount = 16'h0000;
      repeat (5) @(posedge clk);
      #1;
      rst = 1'b0;
      foreach (probe[i])
      begin
         host.rd(probe[i], 1'b0, b);
         chk(40'(b), 40'h0000000000, "reset or unmapped read");
      end
      foreach (rows[i])
      begin
         repeat (rows[i].n) ev({rows[i].sel[0], rows[i].idx}, rows[i].amt);
         host.fetch(rows[i].sel, rows[i].idx, res);
         chk(res, rows[i].exp, "counter readout");
         host.fetch(rows[i].sel, rows[i].idx, res);
         chk(res, 40'h2000000000, "counter not cleared by read");
      end
      // an event in the clear cycle: pending flag first, then both values kept
      ev(9'h00D, 16'h0002);
      host.wr(mib_pkg::OFS_SELECT, mib_pkg::SEL_PORT_SPACE);
      host.wr(mib_pkg::OFS_INDEX, 8'h0D);
      event_valid = 1'b1;
      event_index = 9'h00D;
      event_amount = 16'h0003;
      fork
         host.rd(mib_pkg::OFS_RESULT_4, 1'b1, b);
         begin
            @(posedge clk);
            #1;
            event_valid = 1'b0;
         end
      join
      chk(40'(b[5]), 40'h0000000000, "valid while pending");
      host.get(1'b0, res);
      chk(res, 40'h2000000002, "latched value");
      host.fetch(mib_pkg::SEL_PORT_SPACE, 8'h0D, res);
      chk(res, 40'h2000000003, "event in clear cycle lost");
      // result bytes ignore writes; select reads back what was written
      host.wr(mib_pkg::OFS_RESULT_0, 8'hFF);
      host.rd(mib_pkg::OFS_RESULT_0, 1'b0, b);
      chk(40'(b), 40'h0000000003, "read-only byte changed");
      // a foreign select code stores the index but starts no read
      ev(9'h00D, 16'h0006);
      host.fetch(8'h1E, 8'h0D, res);
      chk(res, 40'h2000000003, "read started by foreign select code");
      host.rd(mib_pkg::OFS_INDEX, 1'b0, b);
      chk(40'(b), 40'h000000000D, "index not stored under foreign code");
      host.fetch(mib_pkg::SEL_PORT_SPACE, 8'h0D, res);
      chk(res, 40'h2000000006, "counter disturbed by refused trigger");
      host.rd(mib_pkg::OFS_SELECT, 1'b0, b);
      chk(40'(b), 40'h000000001C, "select readback");
      // mid-run reset: a pending count and the last result are both wiped
      ev(9'h00D, 16'h0004);
      @(posedge clk);
      #1;
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      host.rd(mib_pkg::OFS_RESULT_4, 1'b0, b);
      chk(40'(b), 40'h0000000000, "flag byte after mid-run reset");
      host.rd(mib_pkg::OFS_RESULT_0, 1'b0, b);
      chk(40'(b), 40'h0000000000, "low byte after mid-run reset");
      host.fetch(mib_pkg::SEL_PORT_SPACE, 8'h0D, res);
      chk(res, 40'h2000000000, "counter survived reset");
      final_report();
   end
endmodule : mib_counter_indirect_readout_tb
`default_nettype wire
